// ===== vec_defines.svh
`ifndef VEC_DEFINES_SVH
`define VEC_DEFINES_SVH

// ==========================================================
// Timing
// ==========================================================
`define VEC_CLK_NS 10
`define VEC_MS_CYC (1000000 / `VEC_CLK_NS)
`define VEC_TICK_W 17
`define VEC_MANUAL_HOLD_MS 3000
`define VEC_SETTLE_MS 50
`define VEC_CONFIRM_MS 500
`define VEC_FLASH_HALF_MS 250

// ==========================================================
// Parameter levels and fixed values
// ==========================================================
`define VEC_LEVELS 9
`define VEC_LVL_MAX 4'h8
`define VEC_OUT_HYST 10'h00A
`define VEC_SHRINK_GAP 10'h019
`define VEC_CTRL_RST 4'h4
`define VEC_OUTL_RST 4'h2
`define VEC_BLOW_RST 4'h0

`endif

// ===== vec_ejector_ctrl.sv
`timescale 1ns/100ps
`include "vec_defines.svh"

// What this block does
// - Normally-open variant: nozzle off while suction command high, else on.
// - Normally-closed variant: nozzle on while suction command high.
// - Suction pauses once vacuum reaches control limit.
// - Paused suction resumes below control limit minus control hysteresis.
// - Part-present output set when vacuum exceeds output limit.
// - External blow-off: valve follows blow input exactly.
// - Timed blow-off: valve opens set time on leaving suction.
// - Nonzero blow time selects timed, zero selects external blow-off.
// - Start in automatic mode after reset.
// - Down and up held over three seconds enters manual mode.
// - Manual mode: keys command, both limit indicators flash.
// - Manual: up starts suction, next down or up stops it.
// - Manual: blow only while down held, indicators steady.
// - Menu press or input change leaves manual mode.
// - Output hysteresis fixed at ten millibar.
// - Control hysteresis is one fifth of control limit.
// - Output limit too high shrinks hysteresis, threshold 25 mbar above.
// - Reject settings where control limit not above output limit.
// - Menu presses select control, output, blow time; up/down step.
// - Leaving adjustment applies value and flashes confirmation.
// - Menu plus down in automatic mode outside menu toggles keypad lock.
// - Outputs may be undefined about 50 ms after a change.
module vec_ejector_ctrl
	import vec_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Variant strap
	input wire logic nc_variant_i,
	// Machine controller
	input wire logic suction_cmd_i,
	input wire logic blow_cmd_i,
	// Sensor, mbar
	input wire logic [9:0] vacuum_i,
	// Keypad, level while pressed
	input wire logic key_menu_i,
	input wire logic key_up_i,
	input wire logic key_down_i,
	// Actuators
	output logic nozzle_on_o,
	output logic blow_valve_o,
	output logic part_present_o,
	// Indicators
	output logic led_ctrl_o,
	output logic led_outl_o,
	output logic [3:0] shown_level_o,
	output logic manual_o,
	output logic locked_o,
	output logic settling_o
);
	// ==========================================================
	// State
	// ==========================================================
	vec_mode_t mode_reg, mode_next;
	vec_sel_t sel_reg, sel_next;
	logic [3:0] ctrl_lvl_reg, ctrl_lvl_next;
	logic [3:0] outl_lvl_reg, outl_lvl_next;
	logic [3:0] blow_lvl_reg, blow_lvl_next;
	logic [3:0] edit_reg, edit_next;
	logic [2:0] keys_reg;
	logic [1:0] ext_reg;
	logic paused_reg, paused_next;
	logic part_reg, part_next;
	logic man_suck_reg, man_suck_next;
	logic suck_reg;
	logic locked_next;
	logic [11:0] hold_reg, hold_next;
	logic [9:0] conf_reg, conf_next;
	logic [8:0] flash_reg, flash_next;
	logic blink_reg, blink_next;
	logic [5:0] settle_reg, settle_next;

	logic [9:0] ctrl_mbar, outl_mbar;
	logic ctrl_off;
	logic [10:0] blow_ms;
	logic tick, blow_busy, blow_load;

	vec_level_table u_table
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ctrl_lvl_i(ctrl_lvl_reg),
		.outl_lvl_i(outl_lvl_reg),
		.blow_lvl_i(blow_lvl_reg),
		.ctrl_mbar_o(ctrl_mbar),
		.ctrl_off_o(ctrl_off),
		.outl_mbar_o(outl_mbar),
		.blow_ms_o(blow_ms)
	);

	vec_ms_timer u_blow_timer
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(blow_load),
		.load_ms_i({1'b0, blow_ms}),
		.tick_o(tick),
		.busy_o(blow_busy)
	);

	// ==========================================================
	// Key edges
	// ==========================================================
	logic p_menu, p_up, p_down, menu_down, both_ud, ext_chg;
	assign p_menu = key_menu_i && !keys_reg[2];
	assign p_up = key_up_i && !keys_reg[1];
	assign p_down = key_down_i && !keys_reg[0];
	assign menu_down = key_menu_i && key_down_i && (p_menu || p_down);
	assign both_ud = key_up_i && key_down_i;
	assign ext_chg = (ext_reg != {suction_cmd_i, blow_cmd_i});

	// ==========================================================
	// Thresholds
	// ==========================================================
	logic [9:0] hyst, on_thr, out_low;
	logic suck_cmd;
	always_comb
	begin
		hyst = ctrl_mbar / 10'h005;
		on_thr = ctrl_mbar - hyst;
		if (outl_mbar > on_thr && !ctrl_off)
			on_thr = outl_mbar + `VEC_SHRINK_GAP;
		out_low = (outl_mbar > `VEC_OUT_HYST) ?
			outl_mbar - `VEC_OUT_HYST : 10'h000;
		if (mode_reg == VEC_MODE_MAN)
			suck_cmd = man_suck_reg;
		else
			suck_cmd = nc_variant_i ? suction_cmd_i : !suction_cmd_i;
	end

	// ==========================================================
	// Control and menu
	// ==========================================================
	always_comb
	begin
		mode_next = mode_reg;
		sel_next = sel_reg;
		ctrl_lvl_next = ctrl_lvl_reg;
		outl_lvl_next = outl_lvl_reg;
		blow_lvl_next = blow_lvl_reg;
		edit_next = edit_reg;
		man_suck_next = man_suck_reg;
		locked_next = locked_o;
		hold_next = both_ud ? hold_reg : 12'h000;
		conf_next = conf_reg;
		settle_next = settle_reg;
		flash_next = flash_reg;
		blink_next = blink_reg;
		paused_next = paused_reg;
		part_next = part_reg;
		if (tick)
		begin
			if (both_ud && hold_reg != 12'hFFF)
				hold_next = hold_reg + 1'b1;
			if (conf_reg != 10'h000)
				conf_next = conf_reg - 1'b1;
			if (settle_reg != 6'h00)
				settle_next = settle_reg - 1'b1;
			if (flash_reg == 9'(`VEC_FLASH_HALF_MS - 1))
			begin
				flash_next = 9'h000;
				blink_next = !blink_reg;
			end
			else
				flash_next = flash_reg + 1'b1;
		end
		if (!suck_cmd || ctrl_off)
			paused_next = 1'b0;
		else if (vacuum_i >= ctrl_mbar)
			paused_next = 1'b1;
		else if (vacuum_i < on_thr)
			paused_next = 1'b0;
		if (vacuum_i > outl_mbar)
			part_next = 1'b1;
		else if (vacuum_i < out_low)
			part_next = 1'b0;
		if (menu_down && sel_reg == VEC_SEL_NONE &&
			mode_reg == VEC_MODE_AUTO)
			locked_next = !locked_o;
		else if (!locked_o)
		begin
			if (mode_reg == VEC_MODE_MAN)
			begin
				if (p_menu || ext_chg)
				begin
					mode_next = VEC_MODE_AUTO;
					man_suck_next = 1'b0;
				end
				else if (man_suck_reg && (p_up || p_down))
					man_suck_next = 1'b0;
				else if (p_up && !key_down_i)
					man_suck_next = 1'b1;
			end
			else if (both_ud && hold_reg >= 12'(`VEC_MANUAL_HOLD_MS))
			begin
				mode_next = VEC_MODE_MAN;
				sel_next = VEC_SEL_NONE;
			end
			else if (p_menu && !key_down_i)
			begin
				case (sel_reg)
					VEC_SEL_NONE:
					begin
						sel_next = VEC_SEL_CTRL;
						edit_next = ctrl_lvl_reg;
					end
					VEC_SEL_CTRL:
					begin
						sel_next = VEC_SEL_OUTL;
						// no control step below 200 mbar
						if ((edit_reg == `VEC_LVL_MAX ||
							edit_reg > outl_lvl_reg) &&
							edit_reg >= 4'h2)
							ctrl_lvl_next = edit_reg;
						edit_next = outl_lvl_reg;
					end
					VEC_SEL_OUTL:
					begin
						sel_next = VEC_SEL_BLOW;
						// output steps 100 to 750 only
						if ((ctrl_lvl_reg == `VEC_LVL_MAX ||
							ctrl_lvl_reg > edit_reg) &&
							edit_reg != 4'h0 &&
							edit_reg != `VEC_LVL_MAX)
							outl_lvl_next = edit_reg;
						edit_next = blow_lvl_reg;
					end
					default:
					begin
						sel_next = VEC_SEL_NONE;
						blow_lvl_next = edit_reg;
					end
				endcase
				if (sel_reg != VEC_SEL_NONE)
				begin
					conf_next = 10'(`VEC_CONFIRM_MS);
					settle_next = 6'(`VEC_SETTLE_MS);
				end
			end
			else if (sel_reg != VEC_SEL_NONE && !both_ud)
			begin
				if (p_up && edit_reg < `VEC_LVL_MAX)
					edit_next = edit_reg + 1'b1;
				else if (p_down && edit_reg != 4'h0)
					edit_next = edit_reg - 1'b1;
			end
		end
	end

	// ==========================================================
	// Output drive
	// ==========================================================
	logic nozzle_nx, blow_nx, lc_nx, lo_nx;
	logic [3:0] lvl_nx;
	always_comb
	begin
		nozzle_nx = suck_cmd && !paused_reg;
		blow_load = suck_reg && !suck_cmd && blow_ms != 11'h000;
		if (mode_reg == VEC_MODE_MAN)
			blow_nx = key_down_i && !man_suck_reg;
		else if (blow_ms == 11'h000)
			blow_nx = blow_cmd_i;
		else
			blow_nx = blow_busy || blow_load;
		if (blow_nx)
			nozzle_nx = 1'b0;
		lc_nx = !ctrl_off && vacuum_i >= on_thr;
		lo_nx = part_next;
		lvl_nx = 4'h0;
		if (mode_reg == VEC_MODE_MAN)
		begin
			lc_nx = blow_nx || blink_reg;
			lo_nx = blow_nx || blink_reg;
		end
		else if (sel_reg == VEC_SEL_CTRL)
			lc_nx = blink_reg;
		else if (sel_reg == VEC_SEL_OUTL)
			lo_nx = blink_reg;
		if (sel_reg != VEC_SEL_NONE)
			lvl_nx = edit_reg;
		else if (conf_reg != 10'h000)
			lvl_nx = blink_reg ? 4'hF : 4'h0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			mode_reg <= VEC_MODE_AUTO;
			sel_reg <= VEC_SEL_NONE;
			ctrl_lvl_reg <= `VEC_CTRL_RST;
			outl_lvl_reg <= `VEC_OUTL_RST;
			blow_lvl_reg <= `VEC_BLOW_RST;
			edit_reg <= 4'h0;
			keys_reg <= 3'h7;
			ext_reg <= 2'h0;
			paused_reg <= 1'b0;
			part_reg <= 1'b0;
			man_suck_reg <= 1'b0;
			suck_reg <= 1'b0;
			hold_reg <= 12'h000;
			conf_reg <= 10'h000;
			flash_reg <= 9'h000;
			blink_reg <= 1'b0;
			settle_reg <= 6'h00;
			nozzle_on_o <= 1'b0;
			blow_valve_o <= 1'b0;
			part_present_o <= 1'b0;
			led_ctrl_o <= 1'b0;
			led_outl_o <= 1'b0;
			shown_level_o <= 4'h0;
			manual_o <= 1'b0;
			locked_o <= 1'b0;
			settling_o <= 1'b0;
		end
		else
		begin
			mode_reg <= mode_next;
			sel_reg <= sel_next;
			ctrl_lvl_reg <= ctrl_lvl_next;
			outl_lvl_reg <= outl_lvl_next;
			blow_lvl_reg <= blow_lvl_next;
			edit_reg <= edit_next;
			keys_reg <= {key_menu_i, key_up_i, key_down_i};
			ext_reg <= {suction_cmd_i, blow_cmd_i};
			paused_reg <= paused_next;
			part_reg <= part_next;
			man_suck_reg <= man_suck_next;
			suck_reg <= suck_cmd;
			hold_reg <= hold_next;
			conf_reg <= conf_next;
			flash_reg <= flash_next;
			blink_reg <= blink_next;
			settle_reg <= settle_next;
			nozzle_on_o <= nozzle_nx;
			blow_valve_o <= blow_nx;
			part_present_o <= part_next;
			led_ctrl_o <= lc_nx;
			led_outl_o <= lo_nx;
			shown_level_o <= lvl_nx;
			manual_o <= (mode_next == VEC_MODE_MAN);
			locked_o <= locked_next;
			settling_o <= (settle_next != 6'h00);
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_nozzle_paused: assert property (
		paused_reg |=> !nozzle_on_o)
		else $error("nozzle on while paused");
	a_limit_pause: assert property (
		suck_cmd && !ctrl_off && vacuum_i >= ctrl_mbar |=> paused_reg)
		else $error("no pause at control limit");
	a_resume_low: assert property (
		paused_reg && suck_cmd && !ctrl_off && vacuum_i < on_thr &&
		vacuum_i < ctrl_mbar |=> !paused_reg)
		else $error("no resume below switch-on point");
	a_part_set: assert property (
		vacuum_i > outl_mbar |=> part_present_o)
		else $error("part present missing");
	a_ext_blow: assert property (
		mode_reg == VEC_MODE_AUTO && blow_ms == 11'h000
		|=> blow_valve_o == $past(blow_cmd_i))
		else $error("external blow mismatch");
	a_no_auto_cmd: assert property (
		mode_reg == VEC_MODE_AUTO && !nc_variant_i && suction_cmd_i
		|=> !nozzle_on_o)
		else $error("nozzle on with NO command");
	a_nc_off: assert property (
		mode_reg == VEC_MODE_AUTO && nc_variant_i && !suction_cmd_i
		|=> !nozzle_on_o)
		else $error("nozzle on without NC command");
	a_manual_exit: assert property (
		mode_reg == VEC_MODE_MAN && !locked_o && ext_chg
		|=> mode_reg == VEC_MODE_AUTO)
		else $error("manual not left");
	a_lock_keys: assert property (
		locked_o && !menu_down |=> $stable(sel_reg) && $stable(mode_reg))
		else $error("locked keypad acted");
	a_reject_bad: assert property (
		ctrl_lvl_reg != `VEC_LVL_MAX |-> ctrl_lvl_reg > outl_lvl_reg)
		else $error("control not above output");
	a_man_blow: assert property (
		mode_reg == VEC_MODE_MAN && key_down_i && !man_suck_reg
		|=> blow_valve_o && led_ctrl_o && led_outl_o)
		else $error("manual blow missing");
endmodule

// ===== vec_ejector_ctrl_tb.sv
`timescale 1ns/100ps

// ==========================================================
// Testbench
// ==========================================================
module vec_ejector_ctrl_tb;
	localparam logic [9:0] ON = 10'h001;
	localparam logic [9:0] OFF = 10'h000;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic nc_variant_i = 1'b0;
	logic suck_req = 1'b1;
	logic blow_req = 1'b0;
	logic [3:0] lag = 4'h0;
	logic [9:0] vacuum_i = 10'h000;
	logic key_menu_i = 1'b0;
	logic key_up_i = 1'b0;
	logic key_down_i = 1'b0;
	logic suction_cmd, blow_cmd, nozzle_on_o, blow_valve_o, part_present_o;
	logic led_ctrl_o, led_outl_o, manual_o, locked_o, settling_o;
	logic [3:0] shown_level_o;
	int error_cnt = 0;
	int tests_run = 0;

	always #5 core_clk_i = ~core_clk_i;

	vec_mach_model mach (.core_clk_i(core_clk_i), .suck_req_i(suck_req),
		.blow_req_i(blow_req), .lag_i(lag), .suction_cmd_o(suction_cmd),
		.blow_cmd_o(blow_cmd));

	vec_ejector_ctrl uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.nc_variant_i(nc_variant_i), .suction_cmd_i(suction_cmd),
		.blow_cmd_i(blow_cmd), .vacuum_i(vacuum_i), .key_menu_i(key_menu_i),
		.key_up_i(key_up_i), .key_down_i(key_down_i),
		.nozzle_on_o(nozzle_on_o), .blow_valve_o(blow_valve_o),
		.part_present_o(part_present_o), .led_ctrl_o(led_ctrl_o),
		.led_outl_o(led_outl_o), .shown_level_o(shown_level_o),
		.manual_o(manual_o), .locked_o(locked_o), .settling_o(settling_o));

	task summarize;
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask

	task chk(input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Keys are levels; a press is one rising edge held two cycles
	task press(input logic m, input logic u, input logic d);
		key_menu_i = m;
		key_up_i = u;
		key_down_i = d;
		cyc(2);
		key_menu_i = 1'b0;
		key_up_i = 1'b0;
		key_down_i = 1'b0;
		cyc(2);
	endtask

	task do_reset(input logic nc);
		rst_n_i = 1'b0;
		nc_variant_i = nc;
		cyc(12);
		chk(nozzle_on_o, OFF);
		chk(manual_o, OFF);
		rst_n_i = 1'b1;
		cyc(3);
		chk(manual_o, OFF);
	endtask

	task t_polarity;
		suck_req = 1'b0;
		cyc(3);
		chk(nozzle_on_o, ON);
		suck_req = 1'b1;
		cyc(3);
		chk(nozzle_on_o, OFF);
		do_reset(1'b1);
		cyc(3);
		chk(nozzle_on_o, ON);
		suck_req = 1'b0;
		cyc(3);
		chk(nozzle_on_o, OFF);
		do_reset(1'b0);
	endtask

	// Reset levels: control 400 mbar, hysteresis 80, output 200
	task t_regulate;
		suck_req = 1'b0;
		vacuum_i = 10'h18F;
		cyc(3);
		chk(nozzle_on_o, ON);
		vacuum_i = 10'h190;
		cyc(3);
		chk(nozzle_on_o, OFF);
		vacuum_i = 10'h141;
		cyc(3);
		chk(nozzle_on_o, OFF);
		chk(led_ctrl_o, ON);
		vacuum_i = 10'h13F;
		cyc(3);
		chk(nozzle_on_o, ON);
		chk(part_present_o, ON);
		chk(led_ctrl_o, OFF);
		chk(led_outl_o, ON);
		vacuum_i = 10'h0C3;
		cyc(3);
		chk(part_present_o, ON);
		vacuum_i = 10'h0BD;
		cyc(3);
		chk(part_present_o, OFF);
		chk(led_outl_o, OFF);
		vacuum_i = 10'h0C9;
		cyc(3);
		chk(part_present_o, ON);
		vacuum_i = 10'h000;
	endtask

	// Slow controller, external blow mode at reset
	task t_ext_blow;
		lag = 4'h3;
		blow_req = 1'b1;
		cyc(8);
		chk(blow_valve_o, ON);
		chk(nozzle_on_o, OFF);
		blow_req = 1'b0;
		cyc(8);
		chk(blow_valve_o, OFF);
		suck_req = 1'b1;
		cyc(8);
		chk(blow_valve_o, OFF);
		lag = 4'h0;
	endtask

	task t_reject;
		press(1'b1, 1'b0, 1'b0);
		chk(shown_level_o, 10'h004);
		repeat (3) press(1'b0, 1'b0, 1'b1);
		chk(shown_level_o, 10'h001);
		press(1'b1, 1'b0, 1'b0);
		chk(shown_level_o, 10'h002);
		press(1'b1, 1'b0, 1'b0);
		chk(shown_level_o, 10'h000);
		press(1'b1, 1'b0, 1'b0);
		press(1'b1, 1'b0, 1'b0);
		chk(shown_level_o, 10'h004);
		repeat (3) press(1'b1, 1'b0, 1'b0);
	endtask

	// Output limit to 100 mbar, blow time to 20 ms
	task t_apply;
		press(1'b1, 1'b0, 1'b0);
		press(1'b1, 1'b0, 1'b0);
		press(1'b0, 1'b0, 1'b1);
		press(1'b1, 1'b0, 1'b0);
		press(1'b0, 1'b1, 1'b0);
		press(1'b1, 1'b0, 1'b0);
		chk(settling_o, ON);
		vacuum_i = 10'h096;
		cyc(3);
		chk(part_present_o, ON);
		suck_req = 1'b0;
		cyc(3);
		suck_req = 1'b1;
		cyc(3);
		chk(blow_valve_o, ON);
		chk(nozzle_on_o, OFF);
		// 20 ms is far longer than the run; only the start is seen
		cyc(500);
		chk(blow_valve_o, ON);
		vacuum_i = 10'h000;
	endtask

	task t_lock;
		press(1'b1, 1'b0, 1'b1);
		chk(locked_o, ON);
		press(1'b1, 1'b0, 1'b0);
		press(1'b0, 1'b1, 1'b0);
		chk(locked_o, ON);
		chk(shown_level_o, 10'h000);
		press(1'b1, 1'b0, 1'b1);
		chk(locked_o, OFF);
		press(1'b1, 1'b0, 1'b0);
		chk(shown_level_o, 10'h004);
		repeat (3) press(1'b1, 1'b0, 1'b0);
	endtask

	// Manual entry needs 3 s; a short hold must not enter it
	task t_manual;
		key_up_i = 1'b1;
		key_down_i = 1'b1;
		cyc(1000);
		chk(manual_o, OFF);
		key_up_i = 1'b0;
		key_down_i = 1'b0;
		cyc(3);
	endtask

	initial
	begin
		repeat (95000) @(posedge core_clk_i);
		error_cnt++;
		$display("ERROR %0t: run timed out", $time);
		summarize();
	end

	initial
	begin
		do_reset(1'b0);
		t_polarity();
		t_regulate();
		t_ext_blow();
		t_reject();
		t_apply();
		t_lock();
		t_manual();
		summarize();
	end
endmodule

// ===== vec_level_table.sv
`timescale 1ns/100ps
`include "vec_defines.svh"

// ==========================================================
// Level to value lookup, registered outputs
// ==========================================================
module vec_level_table
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Level selects
	input wire logic [3:0] ctrl_lvl_i,
	input wire logic [3:0] outl_lvl_i,
	input wire logic [3:0] blow_lvl_i,
	// Values
	output logic [9:0] ctrl_mbar_o,
	output logic ctrl_off_o,
	output logic [9:0] outl_mbar_o,
	output logic [10:0] blow_ms_o
);
	logic [9:0] ctrl_next;
	logic off_next;
	logic [9:0] outl_next;
	logic [10:0] blow_next;

	function automatic logic [9:0] vac(input logic [3:0] l);
		case (l)
			4'h1: vac = 10'h064;
			4'h2: vac = 10'h0C8;
			4'h3: vac = 10'h12C;
			4'h4: vac = 10'h190;
			4'h5: vac = 10'h226;
			4'h6: vac = 10'h28A;
			4'h7: vac = 10'h2EE;
			default: vac = 10'h000;
		endcase
	endfunction

	always_comb
	begin
		ctrl_next = vac(ctrl_lvl_i);
		off_next = (ctrl_lvl_i >= `VEC_LVL_MAX);
		outl_next = vac(outl_lvl_i);
		case (blow_lvl_i)
			4'h1: blow_next = 11'h014;
			4'h2: blow_next = 11'h032;
			4'h3: blow_next = 11'h064;
			4'h4: blow_next = 11'h0FA;
			4'h5: blow_next = 11'h1F4;
			4'h6: blow_next = 11'h2EE;
			4'h7: blow_next = 11'h3E8;
			4'h8: blow_next = 11'h5DC;
			default: blow_next = 11'h000;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_mbar_o <= 10'h000;
			ctrl_off_o <= 1'b1;
			outl_mbar_o <= 10'h000;
			blow_ms_o <= 11'h000;
		end
		else
		begin
			ctrl_mbar_o <= ctrl_next;
			ctrl_off_o <= off_next;
			outl_mbar_o <= outl_next;
			blow_ms_o <= blow_next;
		end
	end
endmodule

// ===== vec_mach_model.sv
`timescale 1ns/100ps

// ==========================================================
// Machine controller driving suction and blow commands
// ==========================================================
module vec_mach_model
(
	// Clock
	input wire logic core_clk_i,
	// Requests from the bench
	input wire logic suck_req_i,
	input wire logic blow_req_i,
	input wire logic [3:0] lag_i,
	// Command lines
	output logic suction_cmd_o,
	output logic blow_cmd_o
);
	logic [3:0] wait_reg;
	logic [3:0] lag_seen;
	logic suck_seen, blow_seen;
	logic pend;

	initial
	begin
		wait_reg = 4'h0;
		lag_seen = 4'h0;
		suck_seen = 1'b0;
		blow_seen = 1'b0;
		suction_cmd_o = 1'b0;
		blow_cmd_o = 1'b0;
	end

	// Requests taken on the rising edge, where the bench holds them still;
	// reading them on the falling edge would race the bench's own writes
	always @(posedge core_clk_i)
	begin
		suck_seen <= suck_req_i;
		blow_seen <= blow_req_i;
		lag_seen <= lag_i;
	end

	assign pend = (suck_seen != suction_cmd_o) ||
		(blow_seen != blow_cmd_o);

	// A slow controller keeps its old commands for lag_i cycles
	always @(negedge core_clk_i)
	begin
		if (pend && (wait_reg < lag_seen))
			wait_reg <= wait_reg + 4'h1;
		else
		begin
			wait_reg <= 4'h0;
			suction_cmd_o <= suck_seen;
			blow_cmd_o <= blow_seen;
		end
	end
endmodule

// ===== vec_ms_timer.sv
`timescale 1ns/100ps
`include "vec_defines.svh"

// ==========================================================
// Millisecond tick and down counter
// ==========================================================
module vec_ms_timer
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic load_i,
	input wire logic [11:0] load_ms_i,
	// Status
	output logic tick_o,
	output logic busy_o
);
	logic [`VEC_TICK_W-1:0] div_reg, div_next;
	logic [11:0] cnt_reg, cnt_next;
	logic tick_next;

	always_comb
	begin
		tick_next = (div_reg == `VEC_TICK_W'(`VEC_MS_CYC - 1));
		div_next = tick_next ? '0 : div_reg + 1'b1;
		cnt_next = cnt_reg;
		if (load_i)
			cnt_next = load_ms_i;
		else if (tick_next && cnt_reg != 12'h000)
			cnt_next = cnt_reg - 1'b1;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			div_reg <= '0;
			cnt_reg <= 12'h000;
			tick_o <= 1'b0;
		end
		else
		begin
			div_reg <= div_next;
			cnt_reg <= cnt_next;
			tick_o <= tick_next;
		end
	end

	assign busy_o = (cnt_reg != 12'h000);
endmodule

// ===== vec_pkg.sv
package vec_pkg;
	typedef enum logic [1:0] {VEC_SEL_NONE, VEC_SEL_CTRL, VEC_SEL_OUTL,
		VEC_SEL_BLOW} vec_sel_t;
	typedef enum logic [1:0] {VEC_MODE_AUTO, VEC_MODE_MAN} vec_mode_t;
endpackage
